// ===== core/bpd_pkg.sv
// Purpose: Shared constants for the bidirectional port block
// Assumes: CPU register port gives byte address, data, write strobe, bit mask
// Notes:   Direction bit 0 drives the pin, 1 releases it
// Functional notes
// - Direction bit: 0 output driving, 1 input
// - Reset loads all direction bits with ones
// - Direction registers take bit and byte writes
// - Output mode write stores latch, drives pin
// - Latch holds value until next write
// - Input mode write updates latch, pin unchanged
// - Output mode read returns latch, unchanged
// - Input mode read returns pin level
// - Output mode arithmetic uses and writes latch
// - Input mode arithmetic leaves latch undefined
// - Bit operations act as full byte access
// - Eight-pin and two-pin ports, reset input
// - Four-pin input port reads pin levels
package bpd_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [15:0] BPD_PORT0_DATA_ADDR = 16'hFF00;
  localparam logic [15:0] BPD_PORT2_DATA_ADDR = 16'hFF02;
  localparam logic [15:0] BPD_PORT4_DATA_ADDR = 16'hFF04;
  localparam logic [15:0] BPD_PORT0_DIR_ADDR  = 16'hFF20;
  localparam logic [15:0] BPD_PORT2_DIR_ADDR  = 16'hFF22;
  // ---------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------
  localparam int          BPD_P0_W      = 8;
  localparam int          BPD_P2_W      = 2;
  localparam int          BPD_P4_W      = 4;
  localparam logic [7:0]  BPD_DIR_RESET = 8'hFF;
  localparam logic [7:0]  BPD_LAT_RESET = 8'h00;
  localparam logic [7:0]  BPD_P2_UPPER  = 8'hFC;
endpackage

// ===== core/bpd_pin_if.sv
`timescale 1ns/1ps
// Purpose: Carries one port's pin and register signals between modules
// Assumes: Single system clock
// Notes:   Width set per instance
interface bpd_pin_if #(parameter int W = 8);
  logic [W-1:0] dir;
  logic [W-1:0] latch;
  logic [W-1:0] pin_sync;
  logic [W-1:0] read_val;
  modport port (input dir, input latch, output pin_sync, output read_val);
  modport top  (output dir, output latch, input pin_sync, input read_val);
endinterface

// ===== core/bpd_pin_sync.sv
`timescale 1ns/1ps
// Purpose: Pin synchroniser and read multiplexer for one port
// Assumes: Pins asynchronous to sys_clk_in
// Notes:   Level accepted when second and third stage agree
module bpd_pin_sync #(
  parameter int W = 8
) (
  input  wire logic   sys_clk_in,
  input  wire logic   reset_n_in,
  input  wire logic [W-1:0] pin_in,
  bpd_pin_if.port     pif
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] lvl_reg;

  // Three-stage chain; first stage feeds only the second
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Accept a bit only when stages agree, filters metastable edges
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      lvl_reg <= '0;
    end else begin
      lvl_reg <= (s2_reg & ~(s2_reg ^ s3_reg)) | (lvl_reg & (s2_reg ^ s3_reg));
    end
  end

  assign pif.pin_sync = lvl_reg;
  // Output bits read the latch, input bits the pin
  assign pif.read_val = (pif.dir & lvl_reg) | (~pif.dir & pif.latch);
endmodule // bpd_pin_sync

// ===== core/bpd_top.sv
`timescale 1ns/1ps
// Purpose: Two bidirectional ports with direction registers, one input port
// Assumes: CPU gives address, write strobe, read strobe, data and bit mask
// Notes:   Read data registered, valid one cycle after read strobe
module bpd_top (
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic [15:0] cpu_addr_in,
  input  wire logic        cpu_wr_in,
  input  wire logic        cpu_rd_in,
  input  wire logic        cpu_rmw_in,
  input  wire logic [7:0]  cpu_wdata_in,
  input  wire logic [7:0]  cpu_wmask_in,
  output logic      [7:0]  cpu_rdata_out,
  output logic             cpu_rvalid_out,
  input  wire logic [7:0]  port0_pins_in,
  output logic      [7:0]  port0_pins_out,
  output logic      [7:0]  port0_pins_oe_out,
  input  wire logic [1:0]  port2_pins_in,
  output logic      [1:0]  port2_pins_out,
  output logic      [1:0]  port2_pins_oe_out,
  input  wire logic [3:0]  port4_pins_in
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0] p0_dir_reg;
  logic [1:0] p2_dir_reg;
  logic [7:0] p0_lat_reg;
  logic [1:0] p2_lat_reg;
  logic [7:0] rdata_next;

  bpd_pin_if #(.W(8)) p0_if ();
  bpd_pin_if #(.W(2)) p2_if ();
  bpd_pin_if #(.W(4)) p4_if ();

  assign p0_if.dir   = p0_dir_reg;
  assign p0_if.latch = p0_lat_reg;
  assign p2_if.dir   = p2_dir_reg;
  assign p2_if.latch = p2_lat_reg;
  assign p4_if.dir   = 4'hF;
  assign p4_if.latch = 4'h0;

  bpd_pin_sync #(.W(8)) u_p0 (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
                              .pin_in(port0_pins_in), .pif(p0_if));
  bpd_pin_sync #(.W(2)) u_p2 (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
                              .pin_in(port2_pins_in), .pif(p2_if));
  bpd_pin_sync #(.W(4)) u_p4 (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
                              .pin_in(port4_pins_in), .pif(p4_if));

  // Masked merge: bit writes touch only mask bits
  function automatic logic [7:0] bpd_merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                           input logic [7:0] msk);
    bpd_merge = (old_v & ~msk) | (new_v & msk);
  endfunction

  logic [7:0] p2_dir_mrg;
  logic [7:0] p2_lat_mrg;
  logic [7:0] p2_rmw_mrg;

  // Port2 merges done at byte width, only the two live bits are stored
  always_comb begin
    p2_dir_mrg = bpd_merge({6'h00, p2_dir_reg}, cpu_wdata_in, cpu_wmask_in);
    p2_lat_mrg = bpd_merge({6'h00, p2_lat_reg}, cpu_wdata_in, cpu_wmask_in);
    p2_rmw_mrg = bpd_merge({6'h00, p2_if.read_val}, cpu_wdata_in, cpu_wmask_in);
  end

  // ---------------------------------------------------------------
  // Direction registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      p0_dir_reg <= bpd_pkg::BPD_DIR_RESET;
      p2_dir_reg <= bpd_pkg::BPD_DIR_RESET[1:0];
    end else if (cpu_wr_in) begin
      if (cpu_addr_in == bpd_pkg::BPD_PORT0_DIR_ADDR)
        p0_dir_reg <= bpd_merge(p0_dir_reg, cpu_wdata_in, cpu_wmask_in);
      if (cpu_addr_in == bpd_pkg::BPD_PORT2_DIR_ADDR)
        p2_dir_reg <= p2_dir_mrg[1:0];
    end
  end

  // ---------------------------------------------------------------
  // Output latches
  // ---------------------------------------------------------------
  // Bit ops resolve to byte writes of read value: input bits pick up
  // pin levels, which is one form of the undefined latch result
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      p0_lat_reg <= bpd_pkg::BPD_LAT_RESET;
      p2_lat_reg <= bpd_pkg::BPD_LAT_RESET[1:0];
    end else if (cpu_wr_in) begin
      if (cpu_addr_in == bpd_pkg::BPD_PORT0_DATA_ADDR)
        p0_lat_reg <= cpu_rmw_in ? bpd_merge(p0_if.read_val, cpu_wdata_in, cpu_wmask_in)
                                 : bpd_merge(p0_lat_reg, cpu_wdata_in, cpu_wmask_in);
      if (cpu_addr_in == bpd_pkg::BPD_PORT2_DATA_ADDR)
        p2_lat_reg <= cpu_rmw_in ? p2_rmw_mrg[1:0] : p2_lat_mrg[1:0];
    end
  end

  // ---------------------------------------------------------------
  // Pin drive, registered
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      port0_pins_out    <= '0;
      port0_pins_oe_out <= '0;
      port2_pins_out    <= '0;
      port2_pins_oe_out <= '0;
    end else begin
      port0_pins_out    <= p0_lat_reg;
      port0_pins_oe_out <= ~p0_dir_reg;
      port2_pins_out    <= p2_lat_reg;
      port2_pins_oe_out <= ~p2_dir_reg;
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_comb begin
    rdata_next = 8'h00;
    unique case (cpu_addr_in)
      bpd_pkg::BPD_PORT0_DATA_ADDR: rdata_next = p0_if.read_val;
      bpd_pkg::BPD_PORT2_DATA_ADDR: rdata_next = {6'h00, p2_if.read_val};
      bpd_pkg::BPD_PORT4_DATA_ADDR: rdata_next = {4'h0, p4_if.pin_sync};
      bpd_pkg::BPD_PORT0_DIR_ADDR:  rdata_next = p0_dir_reg;
      bpd_pkg::BPD_PORT2_DIR_ADDR:  rdata_next = bpd_pkg::BPD_P2_UPPER | {6'h00, p2_dir_reg};
      default:                      rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      cpu_rdata_out  <= 8'h00;
      cpu_rvalid_out <= 1'b0;
    end else begin
      cpu_rvalid_out <= cpu_rd_in;
      if (cpu_rd_in)
        cpu_rdata_out <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_dir_reset: assert property (@(posedge sys_clk_in) !reset_n_in |=>
    p0_dir_reg == 8'hFF && p2_dir_reg == 2'h3) else $error("dir not ones after reset");
  chk_oe_follows: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    ##1 port0_pins_oe_out == ~$past(p0_dir_reg)) else $error("oe mismatch");
  chk_p2_upper: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    cpu_rd_in && cpu_addr_in == bpd_pkg::BPD_PORT2_DIR_ADDR |=> cpu_rdata_out[7:2] == 6'h3F)
    else $error("upper dir bits not one");
  chk_lat_hold: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    !cpu_wr_in |=> $stable(p0_lat_reg)) else $error("latch changed");
  chk_lat_write: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    cpu_wr_in && !cpu_rmw_in && cpu_wmask_in == 8'hFF && cpu_addr_in == bpd_pkg::BPD_PORT0_DATA_ADDR
    |=> p0_lat_reg == $past(cpu_wdata_in)) else $error("latch write lost");
  chk_rd_out: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    cpu_rd_in && cpu_addr_in == 16'hFF00 && p0_dir_reg == 8'h00
    |=> cpu_rdata_out == $past(p0_lat_reg)) else $error("output read wrong");
  chk_rd_in: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    cpu_rd_in && cpu_addr_in == 16'hFF00 && p0_dir_reg == 8'hFF
    |=> cpu_rdata_out == $past(p0_if.pin_sync)) else $error("input read wrong");
  chk_pin_drive: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    ##1 port2_pins_out == $past(p2_lat_reg)) else $error("pin drive stale");
  cov_out_mode: cover property (@(posedge sys_clk_in) p0_dir_reg == 8'h00 && cpu_wr_in);
  cov_mixed_rmw: cover property (@(posedge sys_clk_in) cpu_rmw_in && p0_dir_reg == 8'h0F);
  cov_p4_read: cover property (@(posedge sys_clk_in) cpu_rd_in && cpu_addr_in == 16'hFF04);
endmodule // bpd_top

// ===== testbench/bpd_pin_model.sv
// Purpose: Far-side pin model resolving driven and external levels
// Assumes: An external source drives every pin that the block releases
// Notes:   Driven pins read back the block's own level
`timescale 1ns/1ps
module bpd_pin_model (
  input  wire logic [7:0] p0_out_in,
  input  wire logic [7:0] p0_oe_in,
  input  wire logic [7:0] p0_ext_in,
  output logic      [7:0] p0_lvl_out,
  input  wire logic [1:0] p2_out_in,
  input  wire logic [1:0] p2_oe_in,
  input  wire logic [1:0] p2_ext_in,
  output logic      [1:0] p2_lvl_out,
  input  wire logic [3:0] p4_ext_in,
  output logic      [3:0] p4_lvl_out
);
  // Wire level: block wins where enabled, else external source
  assign p0_lvl_out = (p0_oe_in & p0_out_in) | (~p0_oe_in & p0_ext_in);
  assign p2_lvl_out = (p2_oe_in & p2_out_in) | (~p2_oe_in & p2_ext_in);
  // Input-only port has no driver on the block side
  assign p4_lvl_out = p4_ext_in;
endmodule // bpd_pin_model

// ===== testbench/testbench.sv
// Purpose: Self-checking bench for the bidirectional port block
// Assumes: Inputs change at the falling clock edge
// Notes:   Pin changes get six edges to pass the synchroniser
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; \
  $display("FAIL %0t got %h exp %h", $time, (a), (e)); end end
module testbench;
  logic        sys_clk_in, reset_n_in, cpu_wr_in, cpu_rd_in, cpu_rmw_in, cpu_rvalid_out;
  logic [15:0] cpu_addr_in;
  logic [7:0]  cpu_wdata_in, cpu_wmask_in, cpu_rdata_out, p0_out, p0_oe, p0_ext, p0_lvl, rd;
  logic [1:0]  p2_out, p2_oe, p2_ext, p2_lvl;
  logic [3:0]  p4_ext, p4_lvl;
  int          n_fail, comparisons;
  bpd_top bpd_top_i (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .cpu_addr_in(cpu_addr_in), .cpu_wr_in(cpu_wr_in), .cpu_rd_in(cpu_rd_in),
    .cpu_rmw_in(cpu_rmw_in), .cpu_wdata_in(cpu_wdata_in), .cpu_wmask_in(cpu_wmask_in),
    .cpu_rdata_out(cpu_rdata_out), .cpu_rvalid_out(cpu_rvalid_out),
    .port0_pins_in(p0_lvl), .port0_pins_out(p0_out), .port0_pins_oe_out(p0_oe),
    .port2_pins_in(p2_lvl), .port2_pins_out(p2_out), .port2_pins_oe_out(p2_oe),
    .port4_pins_in(p4_lvl));
  bpd_pin_model bpd_pin_model_i (.p0_out_in(p0_out), .p0_oe_in(p0_oe), .p0_ext_in(p0_ext),
    .p0_lvl_out(p0_lvl), .p2_out_in(p2_out), .p2_oe_in(p2_oe), .p2_ext_in(p2_ext),
    .p2_lvl_out(p2_lvl), .p4_ext_in(p4_ext), .p4_lvl_out(p4_lvl));
  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  task automatic conclude;
    if (n_fail == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One-cycle write pulse, then time for pins and readback to settle
  task automatic wr(input logic [15:0] a, input logic [7:0] d, m, input logic rmw);
    @(negedge sys_clk_in);
    cpu_addr_in = a;
    cpu_wdata_in = d;
    cpu_wmask_in = m;
    cpu_rmw_in = rmw;
    cpu_wr_in = 1'b1;
    @(negedge sys_clk_in);
    cpu_wr_in = 1'b0;
    cpu_rmw_in = 1'b0;
    repeat (6) @(negedge sys_clk_in);
  endtask
  // Read pulse; valid is a one-cycle pulse so it is polled every cycle
  task automatic rdr(input logic [15:0] a);
    int k;
    @(negedge sys_clk_in);
    cpu_addr_in = a;
    cpu_rd_in = 1'b1;
    @(negedge sys_clk_in);
    cpu_rd_in = 1'b0;
    k = 0;
    while (cpu_rvalid_out !== 1'b1 && k < 4) begin
      @(negedge sys_clk_in);
      k++;
    end
    if (k == 4) begin
      n_fail++;
      conclude();
    end
    rd = cpu_rdata_out;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic s_reset;
    rdr(16'hFF20);
    `CHK(rd, 8'hFF)
    rdr(16'hFF22);
    `CHK(rd, 8'hFF)
    `CHK(p0_oe, 8'h00)
    `CHK(p2_oe, 2'h0)
  endtask
  // Latch written while released must not reach the pins
  task automatic s_input;
    wr(16'hFF00, 8'h5A, 8'hFF, 1'b0);
    `CHK(p0_oe, 8'h00)
    `CHK(p0_lvl, 8'hA5)
    rdr(16'hFF00);
    `CHK(rd, 8'hA5)
  endtask
  task automatic s_output;
    wr(16'hFF20, 8'h00, 8'hFF, 1'b0);
    `CHK(p0_oe, 8'hFF)
    `CHK(p0_out, 8'h5A)
    rdr(16'hFF00);
    `CHK(rd, 8'h5A)
    rdr(16'hFF00);
    `CHK(rd, 8'h5A)
  endtask
  // Mixed directions: arithmetic touches low nibble, upper stays released
  task automatic s_rmw;
    wr(16'hFF20, 8'hF0, 8'hFF, 1'b0);
    `CHK(p0_oe, 8'h0F)
    wr(16'hFF00, 8'h03, 8'h0F, 1'b1);
    `CHK(p0_out[3:0], 4'h3)
    `CHK(p0_oe, 8'h0F)
    `CHK(p0_lvl[7:4], 4'hA)
  endtask
  // Port2 pin0 set to output, pin1 left as input, by one bit write
  task automatic s_port2;
    wr(16'hFF02, 8'h00, 8'hFF, 1'b0);
    wr(16'hFF22, 8'h00, 8'h01, 1'b0);
    rdr(16'hFF22);
    `CHK(rd, 8'hFE)
    `CHK(p2_oe, 2'h1)
    `CHK(p2_out[0], 1'b0)
    wr(16'hFF22, 8'h00, 8'hFF, 1'b0);
    rdr(16'hFF22);
    `CHK(rd, 8'hFC)
  endtask
  // Reset in mid-run must return every pin to input mode
  task automatic s_midreset;
    @(negedge sys_clk_in);
    reset_n_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    `CHK(p0_oe, 8'h00)
    `CHK(p2_oe, 2'h0)
    reset_n_in = 1'b1;
    rdr(16'hFF22);
    `CHK(rd, 8'hFF)
    rdr(16'hFF20);
    `CHK(rd, 8'hFF)
  endtask
  task automatic s_port4;
    p4_ext = 4'h9;
    repeat (6) @(negedge sys_clk_in);
    rdr(16'hFF04);
    `CHK(rd[3:0], 4'h9)
    rdr(16'hFF10);
    `CHK(rd, 8'h00)
  endtask
  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    {cpu_wr_in, cpu_rd_in, cpu_rmw_in, reset_n_in} = 4'h0;
    {cpu_addr_in, cpu_wdata_in, cpu_wmask_in} = 32'h0000_0000;
    {p0_ext, p2_ext, p4_ext} = 14'h0000;
    p0_ext = 8'hA5;
    n_fail = 0;
    comparisons = 0;
    repeat (6) @(negedge sys_clk_in);
    reset_n_in = 1'b1;
    s_reset();
    s_input();
    s_output();
    s_rmw();
    s_port2();
    s_midreset();
    s_port4();
    conclude();
  end
endmodule // testbench
